// file: port_phy_pkg.sv
package port_phy_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses on the plain port)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_P1_CTRL = 4'h0;  // Port 1 PHY control
   localparam logic [3:0] ADDR_P1_STAT = 4'h4;  // Port 1 link status
   localparam logic [3:0] ADDR_P2_DIAG = 4'h8;  // Port 2 cable diag
   localparam logic [3:0] ADDR_P2_CTRL = 4'ha;  // Port 2 PHY control

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] P1_CTRL_RST = 16'h009f;
   localparam logic [15:0] P2_CTRL_RST = 16'h0000;
   localparam logic [15:0] P2_DIAG_RST = 16'h0400;
   localparam logic XOVER_ALG_RST = 1'b1;

   // ------------------------------------------------------------
   // Control field positions
   // ------------------------------------------------------------
   localparam int B_LED_OFF = 15;
   localparam int B_TX_DIS = 14;
   localparam int B_RESTART_AN = 13;
   localparam int B_PWR_DOWN = 11;
   localparam int B_XOVER_DIS = 10;
   localparam int B_FORCE_MDIX = 9;
   localparam int B_FAR_LOOP = 8;
   localparam int B_AN_EN = 7;
   localparam int B_FORCE_SPD = 6;
   localparam int B_FORCE_DPX = 5;
   localparam int B_ADV_HI = 4;

   // Diagnostic register fields
   localparam int B_NEAR_SHORT = 15;
   localparam int B_RES_HI = 14;
   localparam int B_RES_LO = 13;
   localparam int B_DIAG_START = 12;
   localparam int B_FORCE_LINK = 11;
   localparam int B_PWRSAVE_DIS = 10;
   localparam int B_NEAR_LOOP = 9;
   localparam int FAULT_W = 9;

   // Status register fields
   localparam int B_XOVER_ALG = 15;
   localparam int B_POL_REV = 13;
   localparam int B_RX_FC = 12;
   localparam int B_TX_FC = 11;
   localparam int B_SPEED = 10;
   localparam int B_DUPLEX = 9;
   localparam int B_FAR_FAULT = 8;
   localparam int B_MDI = 7;
   localparam int B_LINK_GOOD = 5;
   localparam int B_PARTNER_HI = 4;

   // Cable test result codes
   localparam logic [1:0] DIAG_NORMAL = 2'h0;
   localparam logic [1:0] DIAG_OPEN = 2'h1;
   localparam logic [1:0] DIAG_SHORT = 2'h2;
   localparam logic [1:0] DIAG_FAILED = 2'h3;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   // PHY state reported by analog side for port 1
   typedef struct packed {
      logic pol_rev;
      logic rx_fc;
      logic tx_fc;
      logic speed100;
      logic full_dpx;
      logic far_fault;
      logic mdi;
      logic link_good;
      logic [4:0] partner_abil;
   } phy_status_t;

   // Cable test result from the analog TDR engine
   typedef struct packed {
      logic done;
      logic near_short;
      logic [1:0] result;
      logic [8:0] fault_count;
   } diag_result_t;

   // Diag engine sequencing
   typedef enum logic [1:0] {
      DIAG_IDLE = 2'b01,
      DIAG_RUN = 2'b10
   } diag_state_t;

endpackage

// file: port_phy_control_status_regs.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
// Notes on behaviour
// - Far-end loopback returns port 2 via port 1
// - AN enable resets 1; off uses forces
// - Force speed: 1 is 100BT, 0 10BT
// - Force duplex applies when AN off/failed
// - Advertise bits reset 1; clear suppresses ability
// - Crossover algorithm bit writable, resets 1
// - Status bit 13 shows polarity reversed
// - Bits 12, 11 show rx/tx flow control
// - Bit 10 reports resolved speed
// - Bit 9 reports resolved duplex
// - Bit 8 shows far-end fault
// - Bits 4..0 show partner abilities
// - Diag start bit self-clears when done
// - Result codes normal, open, short, failed
// - Bit 15 flags short under ten metres
// - Nine-bit fault count gives distance
// - Force-link bit forces link pass
// - Power-save bit resets 1, 1 disables
// - Near-end loopback inside port 2 PHY
// - LED off drives all LEDs high
// - Bit 14 disables tx, 13 restarts AN
// - Crossover disable, then force MDI-X
module port_phy_control_status_regs #(
   parameter int LED_N = 4
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [3:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rd_data,
   input wire port_phy_pkg::phy_status_t p1_status,
   input wire port_phy_pkg::diag_result_t p2_diag_in,
   input wire logic p1_an_failed,
   input wire logic [LED_N-1:0] port2_led_raw,
   output logic [LED_N-1:0] port2_led_out,
   output logic p2_diag_start_pulse,
   output logic p1_auto_negotiation_en,
   output logic p1_speed100,
   output logic p1_full_dpx,
   output logic [4:0] p1_adv_abil,
   output logic far_end_loopback,
   output logic p1_tx_disable,
   output logic p1_power_down,
   output logic p1_restart_an,
   output logic crossover_algorithm_select,
   output logic p2_force_link,
   output logic p2_pwrsave_dis,
   output logic p2_near_loopback,
   output logic p2_tx_disable,
   output logic p2_restart_an,
   output logic p2_power_down,
   output logic p2_xover_dis,
   output logic p2_force_mdix,
   output logic p2_far_loopback
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [15:0] p1_ctrl_reg;  // Port 1 control low/high bytes
   logic [15:0] p2_ctrl_reg;  // Port 2 control
   logic xover_alg_reg;  // Crossover algorithm choice
   logic force_link_reg;  // Port 2 force link
   logic pwrsave_dis_reg;  // Port 2 power save disable
   logic near_loop_reg;  // Port 2 near-end loopback
   logic diag_busy_reg;  // Cable test running
   port_phy_pkg::diag_state_t diag_state_reg;
   logic [1:0] diag_res_reg;  // Latched result
   logic near_short_reg;  // Latched short flag
   logic [port_phy_pkg::FAULT_W-1:0] fault_cnt_reg;  // Latched distance
   logic [15:0] rd_next;  // Read mux
   logic wr_p1c, wr_p1s, wr_p2d, wr_p2c;
   logic diag_go;

   // Decoded write strobes
   assign wr_p1c = wr_stb && addr == port_phy_pkg::ADDR_P1_CTRL;
   assign wr_p1s = wr_stb && addr == port_phy_pkg::ADDR_P1_STAT;
   assign wr_p2d = wr_stb && addr == port_phy_pkg::ADDR_P2_DIAG;
   assign wr_p2c = wr_stb && addr == port_phy_pkg::ADDR_P2_CTRL;
   // A write of 1 while idle launches the test
   assign diag_go = wr_p2d && wr_data[port_phy_pkg::B_DIAG_START]
                    && !diag_busy_reg;

   // ------------------------------------------------------------
   // Port 1 control
   // ------------------------------------------------------------
   // Reset leaves AN on and all abilities advertised
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         p1_ctrl_reg <= port_phy_pkg::P1_CTRL_RST;
      end else if (wr_p1c) begin
         p1_ctrl_reg <= wr_data;
      end
   end

   // ------------------------------------------------------------
   // Port 2 control
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         p2_ctrl_reg <= port_phy_pkg::P2_CTRL_RST;
      end else if (wr_p2c) begin
         p2_ctrl_reg <= wr_data;
      end
   end

   // Crossover algorithm select in the status register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         xover_alg_reg <= port_phy_pkg::XOVER_ALG_RST;
      end else if (wr_p1s) begin
         xover_alg_reg <= wr_data[port_phy_pkg::B_XOVER_ALG];
      end
   end

   // Writable diag register controls
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         force_link_reg <= 1'b0;
         pwrsave_dis_reg <= port_phy_pkg::P2_DIAG_RST[
            port_phy_pkg::B_PWRSAVE_DIS];
         near_loop_reg <= 1'b0;
      end else if (wr_p2d) begin
         force_link_reg <= wr_data[port_phy_pkg::B_FORCE_LINK];
         pwrsave_dis_reg <= wr_data[port_phy_pkg::B_PWRSAVE_DIS];
         near_loop_reg <= wr_data[port_phy_pkg::B_NEAR_LOOP];
      end
   end

   // ------------------------------------------------------------
   // Cable test sequencer
   // ------------------------------------------------------------
   // Writes of 1 during a run are ignored; the engine's done
   // ends the run and clears the busy bit by itself
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         diag_state_reg <= port_phy_pkg::DIAG_IDLE;
         diag_busy_reg <= 1'b0;
      end else begin
         case (diag_state_reg)
            port_phy_pkg::DIAG_IDLE: begin
               if (diag_go) begin
                  diag_state_reg <= port_phy_pkg::DIAG_RUN;
                  diag_busy_reg <= 1'b1;
               end
            end
            port_phy_pkg::DIAG_RUN: begin
               if (p2_diag_in.done) begin
                  diag_state_reg <= port_phy_pkg::DIAG_IDLE;
                  diag_busy_reg <= 1'b0;
               end
            end
            default: begin
               diag_state_reg <= port_phy_pkg::DIAG_IDLE;
               diag_busy_reg <= 1'b0;
            end
         endcase
      end
   end

   // Start pulse to the engine, one cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         p2_diag_start_pulse <= 1'b0;
      end else begin
         p2_diag_start_pulse <= diag_go;
      end
   end

   // Results latched when the run ends so reads stay stable
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         diag_res_reg <= port_phy_pkg::DIAG_NORMAL;
         near_short_reg <= 1'b0;
         fault_cnt_reg <= '0;
      end else if (diag_state_reg == port_phy_pkg::DIAG_RUN
                   && p2_diag_in.done) begin
         diag_res_reg <= p2_diag_in.result;
         near_short_reg <= p2_diag_in.near_short;
         fault_cnt_reg <= p2_diag_in.fault_count;
      end
   end

   // ------------------------------------------------------------
   // Read path: data in the cycle after the strobe
   // ------------------------------------------------------------
   always_comb begin
      rd_next = 16'h0000;
      case (addr)
         port_phy_pkg::ADDR_P1_CTRL: rd_next = p1_ctrl_reg;
         port_phy_pkg::ADDR_P1_STAT: begin
            rd_next[port_phy_pkg::B_XOVER_ALG] = xover_alg_reg;
            rd_next[port_phy_pkg::B_POL_REV] = p1_status.pol_rev;
            rd_next[port_phy_pkg::B_RX_FC] = p1_status.rx_fc;
            rd_next[port_phy_pkg::B_TX_FC] = p1_status.tx_fc;
            rd_next[port_phy_pkg::B_SPEED] = p1_status.speed100;
            rd_next[port_phy_pkg::B_DUPLEX] = p1_status.full_dpx;
            rd_next[port_phy_pkg::B_FAR_FAULT] =
               p1_status.far_fault;
            rd_next[port_phy_pkg::B_MDI] = p1_status.mdi;
            rd_next[port_phy_pkg::B_LINK_GOOD] = p1_status.link_good;
            rd_next[port_phy_pkg::B_PARTNER_HI:0] =
               p1_status.partner_abil;
         end
         port_phy_pkg::ADDR_P2_DIAG: begin
            rd_next[port_phy_pkg::B_NEAR_SHORT] = near_short_reg;
            rd_next[port_phy_pkg::B_RES_HI:port_phy_pkg::B_RES_LO] =
               diag_res_reg;
            rd_next[port_phy_pkg::B_DIAG_START] = diag_busy_reg;
            rd_next[port_phy_pkg::B_FORCE_LINK] = force_link_reg;
            rd_next[port_phy_pkg::B_PWRSAVE_DIS] = pwrsave_dis_reg;
            rd_next[port_phy_pkg::B_NEAR_LOOP] = near_loop_reg;
            rd_next[port_phy_pkg::FAULT_W-1:0] = fault_cnt_reg;
         end
         port_phy_pkg::ADDR_P2_CTRL: rd_next = p2_ctrl_reg;
         default: rd_next = 16'h0000;  // Unmapped reads zero
      endcase
   end

   // Read data register; held only for the one answer cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_data <= 16'h0000;
      end else if (rd_stb) begin
         rd_data <= rd_next;
      end else begin
         rd_data <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Port 1 PHY controls, resolved speed and duplex
   // ------------------------------------------------------------
   // Forced duplex also covers a failed negotiation
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         p1_auto_negotiation_en <= port_phy_pkg::P1_CTRL_RST[
            port_phy_pkg::B_AN_EN];
         p1_speed100 <= 1'b0;
         p1_full_dpx <= 1'b0;
         p1_adv_abil <= port_phy_pkg::P1_CTRL_RST[
            port_phy_pkg::B_ADV_HI:0];
      end else begin
         p1_auto_negotiation_en <= p1_ctrl_reg[port_phy_pkg::B_AN_EN];
         p1_speed100 <= p1_ctrl_reg[port_phy_pkg::B_AN_EN]
            ? p1_status.speed100
            : p1_ctrl_reg[port_phy_pkg::B_FORCE_SPD];
         p1_full_dpx <= (p1_ctrl_reg[port_phy_pkg::B_AN_EN]
                         && !p1_an_failed)
            ? p1_status.full_dpx
            : p1_ctrl_reg[port_phy_pkg::B_FORCE_DPX];
         p1_adv_abil <= p1_ctrl_reg[port_phy_pkg::B_ADV_HI:0];
      end
   end

   // Remaining port 1 controls and crossover choice
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         far_end_loopback <= 1'b0;
         p1_tx_disable <= 1'b0;
         p1_power_down <= 1'b0;
         p1_restart_an <= 1'b0;
         crossover_algorithm_select <= port_phy_pkg::XOVER_ALG_RST;
      end else begin
         far_end_loopback <= p1_ctrl_reg[port_phy_pkg::B_FAR_LOOP];
         p1_tx_disable <= p1_ctrl_reg[port_phy_pkg::B_TX_DIS];
         p1_power_down <= p1_ctrl_reg[port_phy_pkg::B_PWR_DOWN];
         p1_restart_an <= p1_ctrl_reg[port_phy_pkg::B_RESTART_AN];
         crossover_algorithm_select <= xover_alg_reg;
      end
   end

   // ------------------------------------------------------------
   // Port 2 PHY controls and LEDs
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         p2_force_link <= 1'b0;
         p2_pwrsave_dis <= port_phy_pkg::P2_DIAG_RST[
            port_phy_pkg::B_PWRSAVE_DIS];
         p2_near_loopback <= 1'b0;
         p2_tx_disable <= 1'b0;
         p2_restart_an <= 1'b0;
         p2_power_down <= 1'b0;
         p2_xover_dis <= 1'b0;
         p2_force_mdix <= 1'b0;
         p2_far_loopback <= 1'b0;
         port2_led_out <= '1;
      end else begin
         p2_force_link <= force_link_reg;
         p2_pwrsave_dis <= pwrsave_dis_reg;
         p2_near_loopback <= near_loop_reg;
         p2_tx_disable <= p2_ctrl_reg[port_phy_pkg::B_TX_DIS];
         p2_restart_an <= p2_ctrl_reg[port_phy_pkg::B_RESTART_AN];
         p2_power_down <= p2_ctrl_reg[port_phy_pkg::B_PWR_DOWN];
         p2_xover_dis <= p2_ctrl_reg[port_phy_pkg::B_XOVER_DIS];
         // Force only takes effect with auto crossover off
         p2_force_mdix <= p2_ctrl_reg[port_phy_pkg::B_XOVER_DIS]
            && p2_ctrl_reg[port_phy_pkg::B_FORCE_MDIX];
         p2_far_loopback <= p2_ctrl_reg[port_phy_pkg::B_FAR_LOOP];
         // LEDs are active low, so off means driven high
         port2_led_out <= p2_ctrl_reg[port_phy_pkg::B_LED_OFF]
            ? '1 : port2_led_raw;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_an_reset;
      @(posedge ref_clk) $fell(reset)
      |-> p1_ctrl_reg == port_phy_pkg::P1_CTRL_RST;
   endproperty
   a_an_reset: assert property (p_an_reset) else $error("ctl reset");

   property p_forced_speed;
      @(posedge ref_clk) disable iff (reset)
      !p1_ctrl_reg[port_phy_pkg::B_AN_EN]
      |=> p1_speed100 == $past(p1_ctrl_reg[port_phy_pkg::B_FORCE_SPD]);
   endproperty
   a_forced_speed: assert property (p_forced_speed)
      else $error("spd");

   property p_forced_dpx;
      @(posedge ref_clk) disable iff (reset)
      p1_an_failed |=> p1_full_dpx ==
         $past(p1_ctrl_reg[port_phy_pkg::B_FORCE_DPX]);
   endproperty
   a_forced_dpx: assert property (p_forced_dpx) else $error("dpx");

   sequence s_diag_launch;
      diag_go ##1 diag_busy_reg;
   endsequence
   property p_diag_start;
      @(posedge ref_clk) disable iff (reset)
      diag_go |-> s_diag_launch ##0 p2_diag_start_pulse;
   endproperty
   a_diag_start: assert property (p_diag_start) else $error("start");

   property p_diag_clear;
      @(posedge ref_clk) disable iff (reset)
      diag_busy_reg && p2_diag_in.done |=> !diag_busy_reg;
   endproperty
   a_diag_clear: assert property (p_diag_clear) else $error("clr");

   property p_result_latch;
      @(posedge ref_clk) disable iff (reset)
      diag_busy_reg && p2_diag_in.done |=>
         diag_res_reg == $past(p2_diag_in.result)
         && fault_cnt_reg == $past(p2_diag_in.fault_count);
   endproperty
   a_result_latch: assert property (p_result_latch)
      else $error("res");

   property p_led_off;
      @(posedge ref_clk) disable iff (reset)
      p2_ctrl_reg[port_phy_pkg::B_LED_OFF] |=> port2_led_out == '1;
   endproperty
   a_led_off: assert property (p_led_off) else $error("led");

   property p_mdix;
      @(posedge ref_clk) disable iff (reset)
      !p2_ctrl_reg[port_phy_pkg::B_XOVER_DIS] |=> !p2_force_mdix;
   endproperty
   a_mdix: assert property (p_mdix) else $error("mdix");

   property p_read_lat;
      @(posedge ref_clk) disable iff (reset)
      rd_stb && addr == port_phy_pkg::ADDR_P2_CTRL |=>
         rd_data == $past(p2_ctrl_reg);
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("rd");

endmodule

// file: tdr_engine_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// Cable test engine stand-in at the far side of the block
// ----------------------------------------------------------
module tdr_engine_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [7:0] delay,
   input wire logic [11:0] verdict,
   output port_phy_pkg::diag_result_t diag
);
   logic [7:0] cnt_reg; // Cycles left in the running test
   logic run_reg; // Test in progress
   // Counts down, then reports done for one cycle only; in every
   // other cycle the result lines toggle, so early sampling is caught
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         run_reg <= 1'b0;
         cnt_reg <= 8'h00;
         diag <= '0;
      end else if (start && !run_reg) begin
         run_reg <= 1'b1;
         cnt_reg <= delay;
         diag <= {1'b0, ~diag[11:0]};
      end else if (run_reg && cnt_reg == 8'h00) begin
         run_reg <= 1'b0;
         diag <= {1'b1, verdict};
      end else begin
         cnt_reg <= cnt_reg - 8'h01;
         diag <= {1'b0, ~diag[11:0]};
      end
   end
endmodule

// file: test_port_phy_control_status_regs.sv
`timescale 1ns/10ps
module test_port_phy_control_status_regs;
   // ----------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [15:0] rd_data;
   port_phy_pkg::phy_status_t p1_status = '0;
   port_phy_pkg::diag_result_t diag;
   logic an_fail = 1'b0;
   logic [3:0] led_raw = 4'h0;
   logic [3:0] led_out;
   logic start, an_en, spd, dpx, far_lb, txd1, pd1, ran1, xalg;
   logic fl2, psd2, nl2, txd2, ran2, pd2, xd2, mdix2, fal2;
   logic [4:0] adv;
   logic [7:0] tdr_delay = 8'h14; // Long enough to see busy
   logic [11:0] verdict = 12'h000; // Result the engine reports
   int errors = 0;
   int cmp_count = 0;
   int pulses = 0; // Start pulses seen by the engine
   int n;
   integer seed = 56703;
   logic [15:0] c1, c2, st, rd;
   logic [31:0] r;

   always #5 ref_clk = ~ref_clk;

   port_phy_control_status_regs uut (
      .ref_clk(ref_clk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data), .p1_status(p1_status), .p2_diag_in(diag),
      .p1_an_failed(an_fail), .port2_led_raw(led_raw),
      .port2_led_out(led_out), .p2_diag_start_pulse(start),
      .p1_auto_negotiation_en(an_en), .p1_speed100(spd),
      .p1_full_dpx(dpx), .p1_adv_abil(adv), .far_end_loopback(far_lb),
      .p1_tx_disable(txd1), .p1_power_down(pd1), .p1_restart_an(ran1),
      .crossover_algorithm_select(xalg), .p2_force_link(fl2),
      .p2_pwrsave_dis(psd2), .p2_near_loopback(nl2),
      .p2_tx_disable(txd2), .p2_restart_an(ran2), .p2_power_down(pd2),
      .p2_xover_dis(xd2), .p2_force_mdix(mdix2), .p2_far_loopback(fal2)
   );

   tdr_engine_model engine (
      .ref_clk(ref_clk), .reset(reset), .start(start),
      .delay(tdr_delay), .verdict(verdict), .diag(diag)
   );

   // Counts start pulses so an accepted restart would show up
   always @(posedge ref_clk) begin
      if (start === 1'b1) pulses++;
   end

   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   task check(input string name, input logic [15:0] seen,
              input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask

   // Read data is taken in the one cycle after the strobe
   task rdr(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Status word as software should see it
   function automatic logic [15:0] exp_status(
      port_phy_pkg::phy_status_t s, logic x);
      return {x, 1'b0, s.pol_rev, s.rx_fc, s.tx_fc, s.speed100,
              s.full_dpx, s.far_fault, s.mdi, 1'b0, s.link_good,
              s.partner_abil};
   endfunction

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      // Reset values, unmapped places
      rdr(port_phy_pkg::ADDR_P1_CTRL, rd);
      check("p1 ctrl reset", rd, port_phy_pkg::P1_CTRL_RST);
      #10 check("read idle", rd_data, 16'h0000);
      rdr(port_phy_pkg::ADDR_P1_STAT, rd);
      check("status reset", rd, exp_status('0, 1'b1));
      rdr(port_phy_pkg::ADDR_P2_DIAG, rd);
      check("diag reset", rd, port_phy_pkg::P2_DIAG_RST);
      rdr(port_phy_pkg::ADDR_P2_CTRL, rd);
      check("p2 ctrl reset", rd, port_phy_pkg::P2_CTRL_RST);
      check("reset outs", {an_en, adv, xalg, psd2}, 16'h00ff);
      wr(4'h2, 16'hffff);
      rdr(4'h2, rd);
      check("unmapped 2", rd, 16'h0000);
      rdr(4'hc, rd);
      check("unmapped c", rd, 16'h0000);
      $display("test reset_values done");
      // Random control words over random line status
      for (int i = 0; i < 12; i++) begin
         r = $random(seed);
         c1 = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : r[15:0];
         c2 = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : r[31:16];
         r = $random(seed);
         // Line status changes right after an edge, like the bus
         @(posedge ref_clk);
         p1_status <= r[12:0];
         an_fail <= r[13];
         led_raw <= r[17:14];
         st = r[31:16];
         wr(port_phy_pkg::ADDR_P1_CTRL, c1);
         wr(port_phy_pkg::ADDR_P2_CTRL, c2);
         wr(port_phy_pkg::ADDR_P1_STAT, st);
         repeat (3) @(posedge ref_clk);
         #1 check("far loop", far_lb, c1[8]);
         check("an enable", an_en, c1[7]);
         check("speed", spd, c1[7] ? p1_status.speed100 : c1[6]);
         check("duplex", dpx, (c1[7] && !an_fail) ?
               p1_status.full_dpx : c1[5]);
         check("advertise", adv, c1[4:0]);
         check("p1 misc", {txd1, ran1, pd1}, {c1[14:13], c1[11]});
         check("xover alg", xalg, st[15]);
         check("leds", led_out, c2[15] ? 4'hf : led_raw);
         check("p2 tx an", {txd2, ran2, pd2}, {c2[14:13], c2[11]});
         check("p2 mdix", {xd2, mdix2}, {c2[10], c2[10] & c2[9]});
         check("p2 far loop", fal2, c2[8]);
         rdr(port_phy_pkg::ADDR_P1_STAT, rd);
         st = exp_status(p1_status, st[15]);
         check("status", rd, st);
         check("partner abil", rd[4:0], st[4:0]);
         rdr(port_phy_pkg::ADDR_P1_CTRL, rd);
         check("p1 readback", rd, c1);
         rdr(port_phy_pkg::ADDR_P2_CTRL, rd);
         check("p2 readback", rd, c2);
      end
      $display("test control_status done");
      // Cable test with every result code, restart while busy
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         @(posedge ref_clk);
         verdict <= {r[0], k[1:0], r[9:1]};
         c2 = {4'h1, r[12:10], 9'h000};
         pulses = 0;
         wr(port_phy_pkg::ADDR_P2_DIAG, c2);
         #1 check("start pulse", start, 1'b1);
         wr(port_phy_pkg::ADDR_P2_DIAG, c2);
         repeat (3) @(posedge ref_clk);
         #1 check("diag ctrl", {fl2, psd2, nl2},
                  c2[11:9]);
         rdr(port_phy_pkg::ADDR_P2_DIAG, rd);
         check("busy", rd[12], 1'b1);
         n = 0;
         while (rd[12] !== 1'b0 && n < 60) begin
            rdr(port_phy_pkg::ADDR_P2_DIAG, rd);
            n++;
         end
         if (n == 60) begin
            errors++;
            report_and_stop;
         end
         check("diag word", rd, {verdict[11:9], 1'b0, c2[11:9],
               verdict[8:0]});
         check("pulse count", 16'(pulses), 16'h0001);
      end
      $display("test cable_test done");
      // Result fields ignore writes
      wr(port_phy_pkg::ADDR_P2_DIAG, 16'he1ff);
      rdr(port_phy_pkg::ADDR_P2_DIAG, rd);
      check("diag ro", rd, {verdict[11:9], 4'h0, verdict[8:0]});
      $display("test read_only done");
      report_and_stop;
   end
endmodule
